// ==== hdl/extbus_pkg.sv ====
// constants and types for the external bus and control pin logic
package extbus_pkg;
  // register bus geometry
  localparam int          ADDR_W        = 8;
  localparam int          DATA_W        = 16;
  // register byte offsets
  localparam logic [7:0]  OFS_CTRL      = 8'h00;
  localparam logic [7:0]  OFS_WAIT      = 8'h04;
  localparam logic [7:0]  OFS_STATUS    = 8'h08;
  localparam logic [7:0]  OFS_USER_OUT  = 8'h0C;
  localparam logic [7:0]  OFS_EXT_WDATA = 8'h10;
  localparam logic [7:0]  OFS_EXT_CMD   = 8'h14;
  localparam logic [7:0]  OFS_EXT_RDATA = 8'h18;
  localparam logic [7:0]  OFS_IRQ_CLR   = 8'h1C;
  // control register fields
  localparam int          CTRL_CODEC_EN = 0;
  localparam int          CTRL_TIMER_EN = 1;
  localparam int          CTRL_IRQ_EN   = 4;   // three enable bits, irq zero first
  // wait control fields: one read bit and one write bit per select value
  localparam int          WAIT_RD_LSB   = 0;
  localparam int          WAIT_WR_LSB   = 8;
  // status register fields
  localparam int          ST_UIN        = 0;   // two user input bits
  localparam int          ST_UOUT       = 2;   // two user output status bits
  localparam int          ST_BUSY       = 4;
  localparam int          ST_HALTED     = 5;
  localparam int          ST_PEND       = 8;   // three pending bits
  // command register fields
  localparam int          CMD_WRITE     = 3;
  // first select value that can belong to on-chip peripherals
  localparam logic [2:0]  SEL_INTERNAL  = 3'h4;
  // vector words in program memory
  localparam logic [11:0] VEC_RESET     = 12'hFFC;
  localparam logic [11:0] VEC_IRQ0      = 12'hFFD;
  localparam logic [11:0] VEC_IRQ1      = 12'hFFE;
  localparam logic [11:0] VEC_IRQ2      = 12'hFFF;
  // reset values
  localparam logic [15:0] CTRL_RST      = 16'h0000;
  localparam logic [15:0] WAIT_RST      = 16'h0000;
  localparam logic [1:0]  UOUT_RST      = 2'h0;
  // clock
  localparam int          CLK_HZ        = 25_000_000;

  typedef enum logic [1:0] {
    B_IDLE = 2'b00,
    B_ACT  = 2'b01,
    B_INT  = 2'b10
  } bus_state_e;

  typedef enum logic [1:0] {
    R_PUSH = 2'b00,
    R_LOAD = 2'b01,
    R_RUN  = 2'b10
  } rst_state_e;
endpackage

// ==== hdl/extbus_ctrl.sv ====
// external register bus, interrupt, halt, reset and user pin control
//
// Notes on behaviour
// - data bus floats except while an access writes an outside register
// - direction low while write data driven, high while bus is input
// - latched three-bit select picks one of eight outside registers
// - selects four to seven go on-chip when codec or timer enabled
// - read data captured on the system clock edge, not the strobe
// - halt high: core runs no-ops and program counter holds
// - halt left by taking an enabled interrupt or by a reset
// - each active-low interrupt pin requests on its rising edge
// - pending priority: zero highest, one middle, two lowest
// - irq one from codec when enabled, irq two from timer when enabled
// - after reset release push program counter then load reset vector
// - ready stretch holds strobe, direction, select and data steady
// - ready sampled on clock edges only during an active access
// - one internal wait state can be inserted, set by wait control
// - user inputs feed branch tests and two status bits
// - user inputs accepted asynchronously
// - user outputs show inverse of their two status bits
// - user output zero is the companion interrupt request line
// - vectors: reset FFC, irq zero FFD, irq one FFE, irq two FFF
// - wait state chosen separately for read and write per select
// - ready watched only during external accesses; high adds waits
module extbus_ctrl
  import extbus_pkg::*;
(
  // clock and reset
  input  wire logic              clk,
  input  wire logic              sys_rst,
  input  wire logic              chip_reset_n,
  // register port
  input  wire logic [ADDR_W-1:0] reg_addr,
  input  wire logic [DATA_W-1:0] reg_wdata,
  input  wire logic              reg_we,
  input  wire logic              reg_re,
  output logic      [DATA_W-1:0] reg_rdata,
  // external bus pins
  input  wire logic [15:0]       periph_data_in,
  output logic      [15:0]       periph_data_out,
  output logic                   periph_data_oe,
  output logic                   bus_direction,
  output logic      [2:0]        periph_register_select,
  output logic                   access_strobe_n,
  input  wire logic              bus_ready_stretch,
  // on-chip peripheral access
  output logic                   int_strobe,
  output logic                   int_write,
  output logic      [2:0]        int_select,
  output logic      [15:0]       int_wdata,
  input  wire logic [15:0]       int_rdata,
  input  wire logic              codec_irq,
  input  wire logic              timer_irq,
  // control pins
  input  wire logic              halt,
  input  wire logic [2:0]        irq_inputs_n,
  input  wire logic [1:0]        user_inputs,
  output logic      [1:0]        user_outputs,
  // core side
  output logic                   core_hold,
  output logic      [1:0]        user_input_test,
  output logic                   irq_take,
  output logic                   pc_push,
  output logic                   vector_load,
  output logic      [11:0]       vector_addr
);

  ////////////////////////////////////////////////////////////////////////
  // state

  // one packed record holds every flip-flop of the block
  typedef struct packed {
    logic [1:0]        rst_sync;
    logic [1:0]        halt_sync;
    logic [1:0]        rdy_sync;
    logic [1:0]        uin_sync0;
    logic [1:0]        uin_sync1;
    logic [2:0]        irq_sync0;
    logic [2:0]        irq_sync1;
    logic [2:0]        irq_prev;
    rst_state_e        rst_st;
    bus_state_e        bus_st;
    logic              waited;
    logic              cmd_write;
    logic [15:0]       ctrl;
    logic [15:0]       waitc;
    logic [1:0]        uout_st;
    logic [15:0]       ext_wdata;
    logic [15:0]       ext_rdata;
    logic [2:0]        pend;
    logic              halted;
    logic [DATA_W-1:0] rdata;
    logic [15:0]       dout;
    logic              doe;
    logic              dir;
    logic [2:0]        sel;
    logic              strobe_n;
    logic              istrobe;
    logic              iwrite;
    logic [2:0]        isel;
    logic [15:0]       iwdata;
    logic [1:0]        uout_pin;
    logic              hold;
    logic [1:0]        utest;
    logic              take;
    logic              push;
    logic              vload;
    logic [11:0]       vaddr;
  } state_s;

  state_s s_r;
  state_s s_nxt;

  // reset image: bus floats, strobe and direction idle high
  function automatic state_s reset_state();
    state_s r;
    r           = '0;
    r.rst_st    = R_PUSH;
    r.bus_st    = B_IDLE;
    r.ctrl      = CTRL_RST;
    r.waitc     = WAIT_RST;
    r.uout_st   = UOUT_RST;
    r.dir       = 1'b1;
    r.strobe_n  = 1'b1;
    r.uout_pin  = ~UOUT_RST;
    // the pin reset synchroniser starts released, so the push and the
    // vector load follow the release of the system reset at once
    r.rst_sync  = 2'h3;
    r.irq_sync0 = 3'h7;
    r.irq_sync1 = 3'h7;
    r.irq_prev  = 3'h7;
    return r;
  endfunction

  // wait bit lookup for a select value and direction
  // bits [7:0] lengthen reads and [15:8] writes, one bit per select
  function automatic logic wait_bit(logic [15:0] w, logic [2:0] sel, logic wr);
    logic [7:0] row;
    row = wr ? w[WAIT_WR_LSB +: 8] : w[WAIT_RD_LSB +: 8];
    return row[sel];
  endfunction

  ////////////////////////////////////////////////////////////////////////
  // next state
  // helpers below are decoded afresh from state and the register port

  logic       codec_en;
  logic       timer_en;
  logic [2:0] irq_en;
  logic [2:0] pin_edge;
  logic [2:0] irq_evt;
  logic [2:0] grant;
  logic       internal;
  logic [2:0] cmd_sel;

  always_comb begin
    s_nxt    = s_r;
    codec_en = s_r.ctrl[CTRL_CODEC_EN];
    timer_en = s_r.ctrl[CTRL_TIMER_EN];
    irq_en   = s_r.ctrl[CTRL_IRQ_EN +: 3];
    cmd_sel  = reg_wdata[2:0];
    internal = 1'b0;
    grant    = 3'h0;

    // two-stage synchronisers on every pin input but the data bus
    // only the second stage of each is read by the logic below
    s_nxt.rst_sync  = {s_r.rst_sync[0], chip_reset_n};
    s_nxt.halt_sync = {s_r.halt_sync[0], halt};
    s_nxt.rdy_sync  = {s_r.rdy_sync[0], bus_ready_stretch};
    s_nxt.uin_sync0 = user_inputs;
    s_nxt.uin_sync1 = s_r.uin_sync0;
    s_nxt.irq_sync0 = irq_inputs_n;
    s_nxt.irq_sync1 = s_r.irq_sync0;
    s_nxt.irq_prev  = s_r.irq_sync1;

    // one-cycle pulses default low
    s_nxt.take    = 1'b0;
    s_nxt.push    = 1'b0;
    s_nxt.vload   = 1'b0;
    s_nxt.istrobe = 1'b0;
    s_nxt.rdata   = '0;

    // rising edge of each pin, on-chip sources replace pins when enabled
    // an enabled on-chip source masks its pin completely
    pin_edge = s_r.irq_sync1 & ~s_r.irq_prev;
    irq_evt  = pin_edge;
    if (codec_en) begin
      irq_evt[1] = codec_irq;
    end
    if (timer_en) begin
      irq_evt[2] = timer_irq;
    end

    // register reads: data one cycle after the strobe
    // unmapped and write-only offsets read as zero
    if (reg_re) begin
      unique case (reg_addr)
        OFS_CTRL:      s_nxt.rdata = s_r.ctrl;
        OFS_WAIT:      s_nxt.rdata = s_r.waitc;
        OFS_STATUS: begin
          s_nxt.rdata[ST_UIN +: 2]  = s_r.uin_sync1;
          s_nxt.rdata[ST_UOUT +: 2] = s_r.uout_st;
          s_nxt.rdata[ST_BUSY]      = (s_r.bus_st != B_IDLE);
          s_nxt.rdata[ST_HALTED]    = s_r.halted;
          s_nxt.rdata[ST_PEND +: 3] = s_r.pend;
        end
        OFS_USER_OUT:  s_nxt.rdata[1:0] = s_r.uout_st;
        OFS_EXT_WDATA: s_nxt.rdata = s_r.ext_wdata;
        OFS_EXT_RDATA: s_nxt.rdata = s_r.ext_rdata;
        default:       s_nxt.rdata = '0;
      endcase
    end

    // register writes
    // read-only and unmapped offsets ignore writes
    if (reg_we) begin
      unique case (reg_addr)
        OFS_CTRL:      s_nxt.ctrl      = reg_wdata;
        OFS_WAIT:      s_nxt.waitc     = reg_wdata;
        OFS_USER_OUT:  s_nxt.uout_st   = reg_wdata[1:0];
        OFS_EXT_WDATA: s_nxt.ext_wdata = reg_wdata;
        OFS_IRQ_CLR:   s_nxt.pend      = s_r.pend & ~reg_wdata[2:0];
        default: begin
        end
      endcase
    end

    // user pins: outputs show the inverse of their status bits
    // user output zero doubles as the companion interrupt request
    s_nxt.uout_pin = ~s_nxt.uout_st;
    s_nxt.utest    = s_r.uin_sync1;

    // pending flags: a new event wins over a clear in the same cycle
    s_nxt.pend = s_nxt.pend | irq_evt;

    // halt latches; released by taking an enabled interrupt or by a reset
    // a grant below clears it in the same cycle, so the core resumes
    if (s_r.halt_sync[1]) begin
      s_nxt.halted = 1'b1;
    end

    // reset sequence, then interrupt grant by fixed priority
    // no grant is made until the reset vector has been loaded
    unique case (s_r.rst_st)
      R_PUSH: begin
        s_nxt.push   = 1'b1;
        s_nxt.rst_st = R_LOAD;
      end
      R_LOAD: begin
        s_nxt.vload  = 1'b1;
        s_nxt.vaddr  = VEC_RESET;
        s_nxt.rst_st = R_RUN;
      end
      R_RUN: begin
        if (s_r.pend[0] && irq_en[0]) begin
          grant = 3'h1;
        end else if (s_r.pend[1] && irq_en[1]) begin
          grant = 3'h2;
        end else if (s_r.pend[2] && irq_en[2]) begin
          grant = 3'h4;
        end
        if (grant != 3'h0) begin
          s_nxt.take   = 1'b1;
          s_nxt.vload  = 1'b1;
          s_nxt.vaddr  = grant[0] ? VEC_IRQ0 : (grant[1] ? VEC_IRQ1 : VEC_IRQ2);
          // a line requested again in its own grant cycle stays pending
          s_nxt.pend   = (s_nxt.pend & ~grant) | irq_evt;
          s_nxt.halted = 1'b0;
        end
      end
      default: s_nxt.rst_st = R_RUN;
    endcase
    s_nxt.hold = s_nxt.halted;

    // external access engine
    // a command while busy is dropped; software polls the busy bit
    unique case (s_r.bus_st)
      B_IDLE: begin
        if (reg_we && reg_addr == OFS_EXT_CMD) begin
          internal = (cmd_sel >= SEL_INTERNAL) && (codec_en || timer_en);
          s_nxt.cmd_write = reg_wdata[CMD_WRITE];
          s_nxt.waited    = 1'b0;
          if (internal) begin
            s_nxt.istrobe = 1'b1;
            s_nxt.iwrite  = reg_wdata[CMD_WRITE];
            s_nxt.isel    = cmd_sel;
            s_nxt.iwdata  = s_r.ext_wdata;
            s_nxt.bus_st  = B_INT;
          end else begin
            s_nxt.sel      = cmd_sel;
            s_nxt.strobe_n = 1'b0;
            s_nxt.dir      = ~reg_wdata[CMD_WRITE];
            s_nxt.doe      = reg_wdata[CMD_WRITE];
            s_nxt.dout     = s_r.ext_wdata;
            s_nxt.bus_st   = B_ACT;
          end
        end
      end
      B_ACT: begin
        // outputs stand unchanged while waiting or stretched
        // the internal wait comes first, then one cycle per stretch edge
        if (wait_bit(s_r.waitc, s_r.sel, s_r.cmd_write) && !s_r.waited) begin
          s_nxt.waited = 1'b1;
        end else if (s_r.rdy_sync[1]) begin
          s_nxt.waited = s_r.waited;
        end else begin
          if (!s_r.cmd_write) begin
            s_nxt.ext_rdata = periph_data_in;
          end
          s_nxt.strobe_n = 1'b1;
          s_nxt.dir      = 1'b1;
          s_nxt.doe      = 1'b0;
          s_nxt.bus_st   = B_IDLE;
        end
      end
      B_INT: begin
        // on-chip read data are sampled in the same cycle as the strobe
        if (!s_r.iwrite) begin
          s_nxt.ext_rdata = int_rdata;
        end
        s_nxt.bus_st = B_IDLE;
      end
      default: s_nxt.bus_st = B_IDLE;
    endcase

    // chip reset pin: restart everything but its own and the halt synchronisers
    // pending requests, halt and register contents are all lost
    if (!s_r.rst_sync[1]) begin
      s_nxt           = reset_state();
      s_nxt.rst_sync  = {s_r.rst_sync[0], chip_reset_n};
      s_nxt.halt_sync = {s_r.halt_sync[0], halt};
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // registers

  // all state in one register, synchronous reset; halt is resynchronised anyway
  // the pin reset is not here: it acts through the next state logic
  always_ff @(posedge clk) begin
    if (sys_rst) begin
      s_r <= reset_state();
    end else begin
      s_r <= s_nxt;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // outputs straight from state
  // every port below is a flip-flop of s_r, none passes through logic

  assign reg_rdata              = s_r.rdata;
  assign periph_data_out        = s_r.dout;
  assign periph_data_oe         = s_r.doe;
  assign bus_direction          = s_r.dir;
  assign periph_register_select = s_r.sel;
  assign access_strobe_n        = s_r.strobe_n;
  assign int_strobe             = s_r.istrobe;
  assign int_write              = s_r.iwrite;
  assign int_select             = s_r.isel;
  assign int_wdata              = s_r.iwdata;
  assign user_outputs           = s_r.uout_pin;
  assign core_hold              = s_r.hold;
  assign user_input_test        = s_r.utest;
  assign irq_take               = s_r.take;
  assign pc_push                = s_r.push;
  assign vector_load            = s_r.vload;
  assign vector_addr            = s_r.vaddr;

endmodule

// ==== bench/extbus_ctrl_props.sv ====
// assertion checker for the external bus and control pin block
module extbus_ctrl_props
  import extbus_pkg::*;
(
  // clock and reset
  input wire logic              clk,
  input wire logic              sys_rst,
  // register port
  input wire logic [ADDR_W-1:0] reg_addr,
  input wire logic [DATA_W-1:0] reg_wdata,
  input wire logic              reg_we,
  // external bus pins
  input wire logic [15:0]       periph_data_out,
  input wire logic              periph_data_oe,
  input wire logic              bus_direction,
  input wire logic [2:0]        periph_register_select,
  input wire logic              access_strobe_n,
  // user pins and core side
  input wire logic [1:0]        user_outputs,
  input wire logic              irq_take,
  input wire logic              pc_push,
  input wire logic              vector_load,
  input wire logic [11:0]       vector_addr
);
  default clocking cb @(posedge clk); endclocking
  default disable iff (sys_rst);
  ////////////////////////////////////////
  // bus drive follows direction and strobe
  property p_oe_dir;
    periph_data_oe != bus_direction;
  endproperty
  a_oe_dir: assert property (p_oe_dir) else $error("drive and direction disagree");
  property p_oe_strobe;
    periph_data_oe |-> !access_strobe_n;
  endproperty
  a_oe_strobe: assert property (p_oe_strobe) else $error("bus driven outside access");
  // pins hold while the strobe stays low
  property p_steady;
    (!access_strobe_n && !$past(access_strobe_n)) |-> $stable(periph_register_select)
      && $stable(bus_direction) && $stable(periph_data_out);
  endproperty
  a_steady: assert property (p_steady) else $error("pins moved in stretch");
  // an outside command to selects zero to three shows its select and direction next cycle
  property p_select;
    (reg_we && reg_addr == OFS_EXT_CMD && access_strobe_n && !reg_wdata[2]) |=>
      !access_strobe_n && periph_register_select == $past(reg_wdata[2:0])
      && bus_direction == !$past(reg_wdata[CMD_WRITE]);
  endproperty
  a_select: assert property (p_select) else $error("select or direction wrong");
  // every access ends in bounded time
  property p_strobe_bound;
    $fell(access_strobe_n) |-> ##[1:12] access_strobe_n;
  endproperty
  a_strobe_bound: assert property (p_strobe_bound) else $error("strobe stuck low");
  // user outputs show the inverse of the written bits
  property p_user_out;
    (reg_we && reg_addr == OFS_USER_OUT) |=> user_outputs == ~$past(reg_wdata[1:0]);
  endproperty
  a_user_out: assert property (p_user_out) else $error("user outputs wrong");
  // reset release: push then reset vector
  property p_reset_seq;
    $fell(sys_rst) |-> ##[0:2] pc_push ##1 (vector_load && vector_addr == VEC_RESET);
  endproperty
  a_reset_seq: assert property (p_reset_seq) else $error("reset sequence wrong");
  // a grant loads an interrupt vector
  property p_irq_vec;
    irq_take |-> vector_load && vector_addr != VEC_RESET;
  endproperty
  a_irq_vec: assert property (p_irq_vec) else $error("grant without vector");
endmodule

bind extbus_ctrl extbus_ctrl_props u_props (.clk, .sys_rst, .reg_addr, .reg_wdata, .reg_we,
  .periph_data_out, .periph_data_oe, .bus_direction, .periph_register_select,
  .access_strobe_n, .user_outputs, .irq_take, .pc_push, .vector_load, .vector_addr);

// ==== bench/ext_periph.sv ====
// outside register bank with optional slow ready
module ext_periph (
  // clock and stall request
  input  wire logic        clk,
  input  wire logic        slow,
  // pins from the device
  input  wire logic        strobe_n,
  input  wire logic        dir,
  input  wire logic [2:0]  sel,
  input  wire logic [15:0] dout,
  // answers to the device
  output logic      [15:0] din,
  output logic             ready
);
  logic [15:0] mem [8];
  logic [15:0] last = 16'h0000;
  logic [15:0] wdat;
  logic [2:0]  wsel;
  logic        wdir;
  int          cnt;
  ////////////////////////////////////////
  // copy access pins mid-cycle, pins change with the strobe edge
  always @(negedge clk) begin
    if (!strobe_n) begin
      wsel <= sel;
      wdat <= dout;
      wdir <= dir;
      last <= din;
    end
  end
  // write data taken on the strobe rising edge
  always @(posedge strobe_n) if (wdir === 1'b0) mem[wsel] = wdat;
  // read data only while selected for input, scrambled otherwise
  assign din = (!strobe_n && dir) ? mem[sel] : ~last;
  // slow mode: ready high until four strobe-low cycles have passed
  always @(posedge clk) begin
    cnt <= strobe_n ? 0 : cnt + 1;
    ready <= slow && (strobe_n || cnt < 3);
  end
endmodule

// ==== bench/tb_extbus_ctrl.sv ====
// self-checking bench for the external bus and control pin block
module tb_extbus_ctrl
  import extbus_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ps;
  typedef struct packed {
    logic [2:0]  sel;
    logic [15:0] dat;
    logic        rdw;
    logic        wrw;
  } row_s;
  row_s        rows [4] = '{'{3'h0, 16'hA5A5, 1'b0, 1'b0}, '{3'h3, 16'h5A5A, 1'b1, 1'b0},
                            '{3'h7, 16'hFFFF, 1'b0, 1'b1}, '{3'h4, 16'h0001, 1'b1, 1'b1}};
  logic        clk, sys_rst, chip_reset_n, reg_we, reg_re, halt, codec_irq, timer_irq, slow;
  logic        periph_data_oe, bus_direction, access_strobe_n, bus_ready_stretch, int_strobe;
  logic        core_hold, irq_take, pc_push, vector_load, int_write;
  logic [1:0]  user_inputs, user_outputs, user_input_test;
  logic [2:0]  irq_inputs_n, periph_register_select, int_select;
  logic [7:0]  reg_addr;
  logic [11:0] vector_addr;
  logic [15:0] int_wdata;
  logic [19:0] iq;
  logic [15:0] reg_wdata, reg_rdata, periph_data_in, periph_data_out, part_dout, wv, rv;
  int          failures, samples_checked, lowcnt, intcnt, cycles;
  logic [11:0] vq [$];
  ////////////////////////////////////////
  assign periph_data_in = periph_data_oe ? periph_data_out : part_dout;
  extbus_ctrl DUT (.clk, .sys_rst, .chip_reset_n, .reg_addr, .reg_wdata, .reg_we, .reg_re,
    .reg_rdata, .periph_data_in, .periph_data_out, .periph_data_oe, .bus_direction,
    .periph_register_select, .access_strobe_n, .bus_ready_stretch, .int_strobe,
    .int_write, .int_select, .int_wdata, .int_rdata(16'hC3C3), .codec_irq, .timer_irq,
    .halt, .irq_inputs_n, .user_inputs, .user_outputs, .core_hold, .user_input_test,
    .irq_take, .pc_push, .vector_load, .vector_addr);
  ext_periph far (.clk, .slow, .strobe_n(access_strobe_n), .dir(bus_direction),
    .sel(periph_register_select), .dout(periph_data_out), .din(part_dout),
    .ready(bus_ready_stretch));
  // clock
  initial begin
    clk = 1'b0;
    forever #20 clk = ~clk;
  end
  // strobe-low cycles, on-chip strobes and loaded vectors
  always @(negedge clk) begin
    if (access_strobe_n === 1'b0) lowcnt++;
    if (int_strobe === 1'b1) begin
      intcnt++;
      iq = {int_write, int_select, int_wdata};
    end
    if (vector_load === 1'b1) vq.push_back(vector_addr);
  end
  // hang guard
  always @(posedge clk) begin
    cycles++;
    if (cycles == 20000) begin
      failures++;
      stop_test();
    end
  end
  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    samples_checked++;
    if (seen !== exp) begin
      failures++;
      $display("unexpected at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask
  task automatic wr(input logic [7:0] a, input logic [15:0] d);
    @(posedge clk);
    reg_addr <= a;
    reg_wdata <= d;
    reg_we <= 1'b1;
    @(posedge clk);
    reg_we <= 1'b0;
  endtask
  task automatic rd(input logic [7:0] a, output logic [15:0] d);
    @(posedge clk);
    reg_addr <= a;
    reg_re <= 1'b1;
    @(posedge clk);
    reg_re <= 1'b0;
    @(negedge clk);
    d = reg_rdata;
  endtask
  // one outside or on-chip access, polled until not busy
  task automatic ext(input logic [2:0] s, input logic w, input logic [15:0] d);
    logic [15:0] st;
    lowcnt = 0;
    intcnt = 0;
    if (w) wr(OFS_EXT_WDATA, d);
    wr(OFS_EXT_CMD, {12'h000, w, s});
    for (int i = 0; i < 40; i++) begin
      rd(OFS_STATUS, st);
      if (st[ST_BUSY] === 1'b0) break;
    end
  endtask
  task automatic irq_pins(input logic [2:0] m);
    vq.delete();
    @(posedge clk);
    irq_inputs_n <= ~m;
    repeat (3) @(posedge clk);
    irq_inputs_n <= 3'h7;
    repeat (12) @(posedge clk);
  endtask
  task automatic stop_test();
    $display("comparisons %0d mismatches %0d", samples_checked, failures);
    if (failures == 0 && samples_checked > 0) $display("verification passed");
    else $display("verification failed");
    $finish;
  endtask
  // main sequence
  initial begin
    sys_rst = 1'b1;
    chip_reset_n = 1'b1;
    reg_addr = 8'h00;
    reg_wdata = 16'h0000;
    reg_we = 1'b0;
    reg_re = 1'b0;
    halt = 1'b0;
    codec_irq = 1'b0;
    timer_irq = 1'b0;
    slow = 1'b0;
    irq_inputs_n = 3'h7;
    user_inputs = 2'h0;
    repeat (20) @(posedge clk);
    chk(user_outputs, 2'h3);
    chk(periph_data_oe, 1'b0);
    sys_rst <= 1'b0;
    repeat (4) @(posedge clk);
    chk(vq[0], VEC_RESET);
    rd(OFS_WAIT, rv);
    chk(rv, WAIT_RST);
    rd(8'h20, rv);
    chk(rv, 16'h0000);
    foreach (rows[i]) begin
      wv = 16'h0000;
      wv[rows[i].sel] = rows[i].rdw;
      wv[8 + rows[i].sel] = rows[i].wrw;
      wr(OFS_WAIT, wv);
      ext(rows[i].sel, 1'b1, rows[i].dat);
      chk(lowcnt, 1 + rows[i].wrw);
      ext(rows[i].sel, 1'b0, 16'h0000);
      chk(lowcnt, 1 + rows[i].rdw);
      rd(OFS_EXT_RDATA, rv);
      chk(rv, rows[i].dat);
    end
    // read-only data register ignores a write
    wr(OFS_EXT_RDATA, 16'h0F0F);
    rd(OFS_EXT_RDATA, rv);
    chk(rv, 16'h0001);
    // slow peripheral stretches both directions
    @(posedge clk);
    slow <= 1'b1;
    wr(OFS_WAIT, 16'h0000);
    ext(3'h2, 1'b1, 16'h1234);
    chk(lowcnt >= 3, 1'b1);
    ext(3'h2, 1'b0, 16'h0000);
    rd(OFS_EXT_RDATA, rv);
    chk(rv, 16'h1234);
    slow <= 1'b0;
    // codec on: upper selects go on-chip
    wr(OFS_CTRL, 16'h0071);
    ext(3'h5, 1'b1, 16'h7777);
    chk(lowcnt, 0);
    chk(intcnt, 1);
    chk(iq, {1'b1, 3'h5, 16'h7777});
    ext(3'h5, 1'b0, 16'h0000);
    rd(OFS_EXT_RDATA, rv);
    chk(rv, 16'hC3C3);
    chk(iq[19:16], 4'h5);
    // user pins
    wr(OFS_USER_OUT, 16'h0001);
    @(posedge clk);
    user_inputs <= 2'h2;
    repeat (4) @(posedge clk);
    chk(user_outputs, 2'h2);
    chk(user_input_test, 2'h2);
    rd(OFS_STATUS, rv);
    chk(rv[3:0], 4'h6);
    // masked line stays pending until cleared
    wr(OFS_CTRL, 16'h0030);
    irq_pins(3'h4);
    chk(vq.size(), 0);
    rd(OFS_STATUS, rv);
    chk(rv[10:8], 3'h4);
    wr(OFS_IRQ_CLR, 16'h0004);
    rd(OFS_STATUS, rv);
    chk(rv[10:8], 3'h0);
    // three lines at once, granted by priority
    wr(OFS_CTRL, 16'h0070);
    irq_pins(3'h7);
    chk(vq.size(), 3);
    chk(vq[0], VEC_IRQ0);
    chk(vq[1], VEC_IRQ1);
    chk(vq[2], VEC_IRQ2);
    // codec and timer own lines one and two
    wr(OFS_CTRL, 16'h0073);
    vq.delete();
    @(posedge clk);
    codec_irq <= 1'b1;
    timer_irq <= 1'b1;
    @(posedge clk);
    codec_irq <= 1'b0;
    timer_irq <= 1'b0;
    repeat (6) @(posedge clk);
    chk(vq[0], VEC_IRQ1);
    chk(vq[1], VEC_IRQ2);
    // halt latches until an interrupt is granted
    halt <= 1'b1;
    repeat (6) @(posedge clk);
    halt <= 1'b0;
    repeat (6) @(negedge clk);
    chk(core_hold, 1'b1);
    irq_pins(3'h1);
    chk(core_hold, 1'b0);
    chk(vq[0], VEC_IRQ0);
    // pin reset restarts push and vector load
    vq.delete();
    chip_reset_n <= 1'b0;
    repeat (3) @(posedge clk);
    chip_reset_n <= 1'b1;
    repeat (10) @(posedge clk);
    chk(vq[0], VEC_RESET);
    rd(OFS_CTRL, rv);
    chk(rv, CTRL_RST);
    stop_test();
  end
endmodule
